// File: pkg/apc_pkg.sv
// shared constants and types for the cell port block
package apc_pkg;
  localparam int CELL_BYTES = 53;
  localparam int FIFO_CELLS = 3;
  localparam int FIFO_BYTES = FIFO_CELLS * CELL_BYTES;
  localparam logic [7:0] LAMP_OSC_CYCLES = 8'hDF;
  localparam logic [5:0] CELL_LAST = 6'h34;
  // register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MARK_WIDTH = 8'h01;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h02;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h03;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  // control fields and reset values
  localparam int CTRL_PORT_LSB = 0;
  localparam int CTRL_PAR_EN_BIT = 5;
  localparam logic [4:0] RST_PORT_ADDR = 5'h00;
  localparam logic RST_PAR_EN = 1'b1;
  localparam logic [7:0] RST_MARK_WIDTH = 8'h08;
  localparam logic [2:0] RST_IRQ_MASK = 3'h0;
  // interrupt status bits
  localparam int IRQ_PAR_BIT = 0;
  localparam int IRQ_MARK_BIT = 1;
  localparam int IRQ_LOS_BIT = 2;
  // status fields
  localparam int STAT_GOOD_BIT = 0;
  localparam int STAT_RXC_LSB = 1;
  localparam int STAT_TXC_LSB = 3;

  typedef struct packed {
    logic       soc;
    logic [7:0] data;
  } apc_byte_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_CELL = 2'b10
  } apc_txst_t;
endpackage : apc_pkg

// File: verilog/apc_sync.sv
// two-flop synchroniser for a bundle of foreign inputs
`timescale 1ns/1ps
module apc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         arst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule : apc_sync

// File: verilog/apc_cellmem.sv
// byte memory holding the cells of one fifo, registered read
`timescale 1ns/1ps
module apc_cellmem #(
  parameter int W  = 9,
  parameter int D  = 159,
  parameter int AW = 8
) (
  input  wire logic          clk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [W-1:0]  wdata_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [W-1:0]  rdata_o
);
  logic [W-1:0] mem [D];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule : apc_cellmem

// File: verilog/apc_top.sv
// Functional notes
// - rx cell available high when cell held
// - rx available released when address mismatches
// - tx available high when cell fits
// - tx available released when address mismatches
// - rx data carries odd parity
// - rx start flag on first byte
// - tx parity checked, flagged, nothing else
// - interrupt held low until status read
// - per source interrupt masks
// - async reset clears everything but the cell memories
// - rx lamp 223 osc cycles per good cell
// - tx lamp 223 osc cycles per cell
// - rx marker pulse, programmable width
// - trigger falling edge inserts marker
// - recovered bit clock driven out
// - marker pre-empts cell on byte boundary
// - signal loss disables rx fifo
`timescale 1ns/1ps
module apc_top (
  input  wire logic              CLK_SYS_I,
  input  wire logic              ARST_N_I,
  input  wire logic [7:0]        REG_ADDR_I,
  input  wire logic [15:0]       REG_WDATA_I,
  input  wire logic              REG_WR_I,
  input  wire logic              REG_RD_I,
  output logic      [15:0]       REG_RDATA_O,
  input  wire logic              RXCLK_I,
  input  wire logic [4:0]        RXADDR_I,
  input  wire logic              RXEN_N_I,
  output logic      [7:0]        RXDATA_O,
  output logic                   RXPARITY_O,
  output logic                   RXSOC_O,
  output logic                   RXCLAV_O,
  output logic                   RXCLAV_OE_N_O,
  input  wire logic              TXCLK_I,
  input  wire logic [4:0]        TXADDR_I,
  input  wire logic              TXEN_N_I,
  input  wire logic [7:0]        TXDATA_I,
  input  wire logic              TXPARITY_I,
  input  wire logic              TXSOC_I,
  output logic                   TXCLAV_O,
  output logic                   TXCLAV_OE_N_O,
  output logic                   IRQ_LINE_N_O,
  output logic                   IRQ_LINE_OE_N_O,
  input  wire logic              LINE_RATE_CLOCK_SOURCE_I,
  output logic                   RECEIVE_ACTIVITY_LAMP_O,
  output logic                   TRANSMIT_ACTIVITY_LAMP_O,
  output logic                   RECEIVED_TIMING_MARKER_PULSE_O,
  input  wire logic              TRANSMIT_TIMING_MARKER_TRIGGER_I,
  input  wire logic              RX_BIT_CLK_I,
  output logic                   RECOVERED_BIT_CLOCK_O,
  output logic                   UNUSED_OUTPUT_FLOAT_O,
  input  wire apc_pkg::apc_byte_t LINE_RX_I,
  input  wire logic              LINE_RX_VALID_I,
  input  wire logic              LINE_RX_ERR_I,
  input  wire logic              LINE_RX_MARKER_I,
  input  wire logic              LINE_GOOD_SIGNAL_I,
  input  wire logic              LINE_TX_SLOT_I,
  output apc_pkg::apc_byte_t     LINE_TX_O,
  output logic                   LINE_TX_VALID_O,
  output logic                   LINE_TX_MARKER_O
);
  import apc_pkg::*;

  function automatic logic [7:0] cell_base(input logic [1:0] c);
    cell_base = (c == 2'h0) ? 8'h00 : (c == 2'h1) ? 8'h35 : 8'h6A;
  endfunction : cell_base

  function automatic logic [1:0] cell_next(input logic [1:0] c);
    cell_next = (c == 2'h2) ? 2'h0 : c + 2'h1;
  endfunction : cell_next

  // foreign inputs, all through two flops before use
  logic [26:0] sy;
  logic [3:0]  prev;
  apc_sync #(.W(27)) u_sync (
    .clk_i    (CLK_SYS_I),
    .arst_n_i (ARST_N_I),
    .d_i      ({RXCLK_I, TXCLK_I, LINE_RATE_CLOCK_SOURCE_I,
                TRANSMIT_TIMING_MARKER_TRIGGER_I, RX_BIT_CLK_I,
                RXEN_N_I, TXEN_N_I, TXSOC_I, TXPARITY_I,
                RXADDR_I, TXADDR_I, TXDATA_I}),
    .q_o      (sy)
  );
  wire       rx_en_n   = sy[21];
  wire       tx_en_n   = sy[20];
  wire       tx_soc    = sy[19];
  wire       tx_par    = sy[18];
  wire [4:0] rx_addr_s = sy[17:13];
  wire [4:0] tx_addr_s = sy[12:8];
  wire [7:0] tx_data   = sy[7:0];
  // utopia clocks are slow, so edges are found by sampling
  wire rxclk_rise = sy[26] & ~prev[3];
  wire txclk_rise = sy[25] & ~prev[2];
  wire osc_rise   = sy[24] & ~prev[1];
  wire transmit_timing_marker_trigger_fall = ~sy[23] & prev[0];

  // register file
  logic [4:0]  port_addr;
  logic        par_en;
  logic [7:0]  mark_width;
  logic [2:0]  irq_mask;
  logic [2:0]  irq_stat;
  logic        good_q;
  wire wr_ctrl  = REG_WR_I && (REG_ADDR_I == OFS_CTRL);
  wire wr_width = REG_WR_I && (REG_ADDR_I == OFS_MARK_WIDTH);
  wire wr_mask  = REG_WR_I && (REG_ADDR_I == OFS_IRQ_MASK);
  wire rd_stat  = REG_RD_I && (REG_ADDR_I == OFS_IRQ_STAT);

  // receive fifo, filled from the line side
  logic [1:0] rx_wr_cell;
  logic [5:0] rx_wr_byte;
  logic       rx_wr_on;
  logic [1:0] rx_cells;
  logic [1:0] rx_rd_cell;
  logic [5:0] rx_rd_byte;
  logic [2:0] rx_good;
  logic       rx_sel;
  logic [7:0] rx_q;
  wire rx_fifo_en = LINE_GOOD_SIGNAL_I;
  wire rx_soc_in  = LINE_RX_I.soc;
  wire rx_take    = LINE_RX_VALID_I && rx_fifo_en &&
                    (rx_soc_in ? (rx_cells != 2'(FIFO_CELLS)) : rx_wr_on);
  wire [5:0] rx_idx = rx_soc_in ? 6'h00 : rx_wr_byte;
  wire rx_last_w  = rx_take && (rx_idx == CELL_LAST);
  wire [7:0] rx_waddr = cell_base(rx_wr_cell) + {2'h0, rx_idx};
  wire [7:0] rx_raddr = cell_base(rx_rd_cell) + {2'h0, rx_rd_byte};
  // rx data is only handed out while this port is selected
  wire rx_emit    = rxclk_rise && !rx_en_n && rx_sel &&
                    (rx_cells != 2'h0);
  wire rx_last_r  = rx_emit && (rx_rd_byte == CELL_LAST);
  wire rx_lamp_go = rx_emit && (rx_rd_byte == 6'h00) &&
                    rx_good[rx_rd_cell];
  wire [1:0] next_rx_cells = rx_cells + 2'(rx_last_w) - 2'(rx_last_r);

  apc_cellmem #(.W(8), .D(FIFO_BYTES), .AW(8)) u_rxmem (
    .clk_i   (CLK_SYS_I),
    .we_i    (rx_take),
    .waddr_i (rx_waddr),
    .wdata_i (LINE_RX_I.data),
    .raddr_i (rx_raddr),
    .rdata_o (rx_q)
  );

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rx_wr_cell <= 2'h0;
      rx_wr_byte <= 6'h00;
      rx_wr_on   <= 1'b0;
      rx_good    <= 3'h0;
    end else begin
      if (!rx_fifo_en) begin
        rx_wr_on <= 1'b0;
      end else if (rx_take) begin
        rx_wr_byte <= rx_idx + 6'h01;
        rx_wr_on   <= !rx_last_w;
        // errored cells do not light the lamp
        rx_good[rx_wr_cell] <= (rx_soc_in | rx_good[rx_wr_cell]) &
                               ~LINE_RX_ERR_I;
        if (rx_last_w) begin
          rx_wr_cell <= cell_next(rx_wr_cell);
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rx_cells   <= 2'h0;
      rx_rd_cell <= 2'h0;
      rx_rd_byte <= 6'h00;
      rx_sel     <= 1'b0;
      RXDATA_O   <= 8'h00;
      RXPARITY_O <= 1'b1;
      RXSOC_O    <= 1'b0;
    end else begin
      rx_cells <= next_rx_cells;
      if (rxclk_rise && rx_en_n) begin
        rx_sel <= (rx_addr_s == port_addr);
      end
      if (rx_emit) begin
        RXDATA_O   <= rx_q;
        RXPARITY_O <= ~^rx_q;
        RXSOC_O    <= (rx_rd_byte == 6'h00);
        rx_rd_byte <= rx_last_r ? 6'h00 : rx_rd_byte + 6'h01;
        if (rx_last_r) begin
          rx_rd_cell <= cell_next(rx_rd_cell);
        end
      end else if (rxclk_rise) begin
        RXSOC_O <= 1'b0;
      end
    end
  end

  // transmit fifo, filled from utopia
  logic [1:0] tx_wr_cell;
  logic [5:0] tx_wr_byte;
  logic       tx_wr_on;
  logic [1:0] tx_cells;
  logic [1:0] tx_rd_cell;
  logic [5:0] tx_rd_byte;
  logic       tx_sel;
  logic       mark_pend;
  logic [7:0] tx_q;
  apc_txst_t  tx_st;
  wire tx_acc    = txclk_rise && !tx_en_n && tx_sel;
  wire tx_take   = tx_acc &&
                   (tx_soc ? (tx_cells != 2'(FIFO_CELLS)) : tx_wr_on);
  wire [5:0] tx_idx = tx_soc ? 6'h00 : tx_wr_byte;
  wire tx_last_w = tx_take && (tx_idx == CELL_LAST);
  wire par_err   = tx_acc && par_en && !(^{tx_data, tx_par});
  wire tx_lamp_go = tx_take && tx_soc;
  // a cell half written still occupies its slot
  wire tx_room   = ({1'b0, tx_cells} + {2'h0, tx_wr_on}) <
                   3'(FIFO_CELLS);
  wire tx_busy   = (tx_st == TX_CELL) || (tx_cells != 2'h0);
  wire tx_send   = LINE_TX_SLOT_I && !mark_pend && tx_busy;
  wire tx_last_r = tx_send && (tx_rd_byte == CELL_LAST);
  wire [7:0] tx_waddr = cell_base(tx_wr_cell) + {2'h0, tx_idx};
  wire [7:0] tx_raddr = cell_base(tx_rd_cell) + {2'h0, tx_rd_byte};
  wire [1:0] next_tx_cells = tx_cells + 2'(tx_last_w) - 2'(tx_last_r);

  apc_cellmem #(.W(8), .D(FIFO_BYTES), .AW(8)) u_txmem (
    .clk_i   (CLK_SYS_I),
    .we_i    (tx_take),
    .waddr_i (tx_waddr),
    .wdata_i (tx_data),
    .raddr_i (tx_raddr),
    .rdata_o (tx_q)
  );

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      tx_wr_cell <= 2'h0;
      tx_wr_byte <= 6'h00;
      tx_wr_on   <= 1'b0;
      tx_sel     <= 1'b0;
    end else begin
      if (txclk_rise && tx_en_n) begin
        tx_sel <= (tx_addr_s == port_addr);
      end
      // a start flag mid cell drops the partial cell
      if (tx_take) begin
        tx_wr_byte <= tx_idx + 6'h01;
        tx_wr_on   <= !tx_last_w;
        if (tx_last_w) begin
          tx_wr_cell <= cell_next(tx_wr_cell);
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      tx_cells         <= 2'h0;
      tx_rd_cell       <= 2'h0;
      tx_rd_byte       <= 6'h00;
      tx_st            <= TX_IDLE;
      mark_pend        <= 1'b0;
      LINE_TX_O        <= '0;
      LINE_TX_VALID_O  <= 1'b0;
      LINE_TX_MARKER_O <= 1'b0;
    end else begin
      tx_cells         <= next_tx_cells;
      LINE_TX_VALID_O  <= 1'b0;
      LINE_TX_MARKER_O <= 1'b0;
      // a new trigger beats the clear of the old one
      mark_pend <= transmit_timing_marker_trigger_fall |
                   (mark_pend & ~LINE_TX_SLOT_I);
      if (LINE_TX_SLOT_I && mark_pend) begin
        LINE_TX_VALID_O  <= 1'b1;
        LINE_TX_MARKER_O <= 1'b1;
        LINE_TX_O        <= '0;
      end else if (tx_send) begin
        LINE_TX_VALID_O <= 1'b1;
        LINE_TX_O.data  <= tx_q;
        LINE_TX_O.soc   <= (tx_rd_byte == 6'h00);
        tx_rd_byte <= tx_last_r ? 6'h00 : tx_rd_byte + 6'h01;
        if (tx_last_r) begin
          tx_rd_cell <= cell_next(tx_rd_cell);
        end
      end
      case (tx_st)
        TX_IDLE: begin
          if (tx_send) begin
            tx_st <= TX_CELL;
          end
        end
        TX_CELL: begin
          if (tx_last_r) begin
            tx_st <= TX_IDLE;
          end
        end
        default: begin
          tx_st <= TX_IDLE;
        end
      endcase
    end
  end

  // lamps and rx marker pulse, widths counted on osc edges
  logic [7:0] pcnt [3];
  logic [2:0] pulse_n;
  wire  [2:0] trig = {LINE_RX_MARKER_I, tx_lamp_go, rx_lamp_go};
  wire  [7:0] pload [3];
  assign pload[0] = LAMP_OSC_CYCLES;
  assign pload[1] = LAMP_OSC_CYCLES;
  assign pload[2] = mark_width;

  for (genvar g = 0; g < 3; g++) begin : g_pulse
    wire [7:0] next_cnt = trig[g] ? pload[g] :
                          (osc_rise && pcnt[g] != 8'h00) ?
                          pcnt[g] - 8'h01 : pcnt[g];
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
        pcnt[g]    <= 8'h00;
        pulse_n[g] <= 1'b1;
      end else begin
        pcnt[g]    <= next_cnt;
        pulse_n[g] <= (next_cnt == 8'h00);
      end
    end
  end

  // control, interrupt and pin registers
  wire [2:0] irq_set = {good_q & ~LINE_GOOD_SIGNAL_I,
                        LINE_RX_MARKER_I, par_err};

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      port_addr <= RST_PORT_ADDR;
      par_en    <= RST_PAR_EN;
      mark_width <= RST_MARK_WIDTH;
      irq_mask  <= RST_IRQ_MASK;
      irq_stat  <= 3'h0;
      good_q    <= 1'b0;
    end else begin
      good_q <= LINE_GOOD_SIGNAL_I;
      if (wr_ctrl) begin
        port_addr <= REG_WDATA_I[CTRL_PORT_LSB +: 5];
        par_en    <= REG_WDATA_I[CTRL_PAR_EN_BIT];
      end
      if (wr_width) begin
        mark_width <= REG_WDATA_I[7:0];
      end
      if (wr_mask) begin
        irq_mask <= REG_WDATA_I[2:0];
      end
      // reading clears, but an event in that cycle survives
      irq_stat <= (rd_stat ? 3'h0 : irq_stat) | irq_set;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      REG_RDATA_O     <= 16'h0000;
      RXCLAV_O        <= 1'b0;
      RXCLAV_OE_N_O   <= 1'b1;
      TXCLAV_O        <= 1'b0;
      TXCLAV_OE_N_O   <= 1'b1;
      IRQ_LINE_N_O    <= 1'b0;
      IRQ_LINE_OE_N_O <= 1'b1;
      RECEIVE_ACTIVITY_LAMP_O        <= 1'b1;
      TRANSMIT_ACTIVITY_LAMP_O       <= 1'b1;
      RECEIVED_TIMING_MARKER_PULSE_O <= 1'b1;
      RECOVERED_BIT_CLOCK_O <= 1'b0;
      UNUSED_OUTPUT_FLOAT_O <= 1'b0;
    end else begin
      case (REG_ADDR_I)
        OFS_CTRL:       REG_RDATA_O <= {10'h000, par_en, port_addr};
        OFS_MARK_WIDTH: REG_RDATA_O <= {8'h00, mark_width};
        OFS_IRQ_MASK:   REG_RDATA_O <= {13'h0000, irq_mask};
        OFS_IRQ_STAT:   REG_RDATA_O <= {13'h0000, irq_stat};
        OFS_STATUS:     REG_RDATA_O <= {11'h000, tx_cells,
                                        rx_cells, good_q};
        default:        REG_RDATA_O <= 16'h0000;
      endcase
      RXCLAV_O      <= (rx_cells != 2'h0);
      RXCLAV_OE_N_O <= (rx_addr_s != port_addr);
      TXCLAV_O      <= tx_room;
      TXCLAV_OE_N_O <= (tx_addr_s != port_addr);
      // open drain: only ever pulls low
      IRQ_LINE_OE_N_O <= ~|(irq_stat & irq_mask);
      RECEIVE_ACTIVITY_LAMP_O        <= pulse_n[0];
      TRANSMIT_ACTIVITY_LAMP_O       <= pulse_n[1];
      RECEIVED_TIMING_MARKER_PULSE_O <= pulse_n[2];
      RECOVERED_BIT_CLOCK_O <= sy[22];
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      prev <= 4'h0;
    end else begin
      prev <= sy[26:23];
    end
  end

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!ARST_N_I);

  AST_RXCLAV: assert property (
    RXCLAV_O == ($past(rx_cells) != 2'h0))
    else $error("rx cell available wrong");
  // the edge after release still shows reset values, so skip it
  AST_RXCLAV_Z: assert property (
    $past(ARST_N_I) |->
    RXCLAV_OE_N_O == ($past(rx_addr_s) != $past(port_addr)))
    else $error("rx available drive wrong");
  AST_TXCLAV: assert property (
    $past(ARST_N_I) && $past(tx_cells) == 2'h0 |-> TXCLAV_O)
    else $error("tx available low with empty fifo");
  AST_TXCLAV_Z: assert property (
    $past(tx_addr_s) != $past(port_addr) |-> TXCLAV_OE_N_O)
    else $error("tx available driven when not addressed");
  AST_RXPAR: assert property (
    ^{RXDATA_O, RXPARITY_O})
    else $error("rx parity not odd");
  AST_RXSOC: assert property (
    $rose(RXSOC_O) |-> rx_rd_byte == 6'h01)
    else $error("rx start flag not on first byte");
  AST_PARERR: assert property (
    par_err |=> irq_stat[IRQ_PAR_BIT])
    else $error("parity error not flagged");
  AST_IRQ: assert property (
    |(irq_stat & irq_mask) && !rd_stat |=> !IRQ_LINE_OE_N_O)
    else $error("interrupt not pulled low");
  AST_RXLAMP: assert property (
    rx_lamp_go |=> pcnt[0] == LAMP_OSC_CYCLES ##1
    !RECEIVE_ACTIVITY_LAMP_O)
    else $error("rx lamp not started");
  AST_MARK: assert property (
    LINE_TX_SLOT_I && mark_pend |=> LINE_TX_MARKER_O && LINE_TX_VALID_O)
    else $error("marker not sent first");
  AST_LOS: assert property (
    !LINE_GOOD_SIGNAL_I |=> !rx_wr_on)
    else $error("rx fifo open without signal");
endmodule : apc_top

// File: verif/apc_layer_model.sv
// behavioural layer device driving the utopia side of the port
`timescale 1ns/1ps
module apc_layer_model (
  output logic            txclk_o,
  output logic            rxclk_o,
  output logic [4:0]      txaddr_o,
  output logic            txen_n_o,
  output logic [7:0]      txdata_o,
  output logic            txpar_o,
  output logic            txsoc_o,
  output logic [4:0]      rxaddr_o,
  output logic            rxen_n_o,
  input  wire logic [7:0] rxdata_i,
  input  wire logic       rxpar_i,
  input  wire logic       rxsoc_i
);
  logic [9:0] rxq [53];
  // both clocks free running, phases unrelated to the system clock
  initial begin
    txclk_o = 1'b0;
    #137;
    forever #200 txclk_o = ~txclk_o;
  end
  initial begin
    rxclk_o = 1'b0;
    #61;
    forever #200 rxclk_o = ~rxclk_o;
  end
  initial begin
    txaddr_o = 5'h1F;
    txen_n_o = 1'b1;
    txdata_o = 8'h00;
    txpar_o  = 1'b1;
    txsoc_o  = 1'b0;
    rxaddr_o = 5'h1F;
    rxen_n_o = 1'b1;
  end
  // select by address with enables idle
  task automatic poll(input logic [4:0] a);
    @(negedge rxclk_o);
    rxaddr_o <= a;
    rxen_n_o <= 1'b1;
    @(negedge txclk_o);
    txaddr_o <= a;
    txen_n_o <= 1'b1;
    repeat (3) @(negedge rxclk_o);
  endtask : poll
  // changes on falling edges so the sampled rise sees settled lines
  task automatic send_cell(input logic [7:0] base, input int bad,
                           input int gap);
    logic [7:0] d;
    for (int i = 0; i < 53; i++) begin
      repeat (gap) begin
        @(negedge txclk_o);
        txen_n_o <= 1'b1;
        txsoc_o  <= 1'b0;
        txdata_o <= ~txdata_o;
      end
      d = base + 8'(i);
      @(negedge txclk_o);
      txen_n_o <= 1'b0;
      txsoc_o  <= (i == 0);
      txdata_o <= d;
      txpar_o  <= ~^d ^ (i == bad);
    end
    @(negedge txclk_o);
    txen_n_o <= 1'b1;
    txsoc_o  <= 1'b0;
    txdata_o <= ~txdata_o;
  endtask : send_cell
  task automatic recv_cell();
    @(negedge rxclk_o);
    rxen_n_o <= 1'b0;
    @(posedge rxclk_o);
    for (int i = 0; i < 53; i++) begin
      @(posedge rxclk_o);
      rxq[i] = {rxsoc_i, rxpar_i, rxdata_i};
      // enable spans 53 rises only, else a byte of the next cell leaks
      if (i == 51) begin
        @(negedge rxclk_o);
        rxen_n_o <= 1'b1;
      end
    end
  endtask : recv_cell
endmodule : apc_layer_model

// File: verif/apc_top_tb.sv
// self-checking bench for the cell port block
`timescale 1ns/1ps
module apc_top_tb;
  import apc_pkg::*;
  logic        clk = 1'b0, osc = 1'b0, arst_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, trig = 1'b1, rbc = 1'b0;
  logic        rx_vld = 1'b0, rx_err = 1'b0, rx_mark = 1'b0, good = 1'b1;
  logic        slot = 1'b0, slot_run = 1'b0;
  apc_byte_t   line_rx = '0;
  apc_byte_t   line_tx;
  logic [15:0] reg_rdata;
  wire  [2:0]  lamp;
  logic        txclk, rxclk, txen_n, rxen_n, txpar, txsoc, tx_vld, tx_mark;
  logic        rxpar, rxsoc, rxclav, rxclav_oe_n, txclav, txclav_oe_n;
  logic        irq_oe_n, irq_n, recovered_bit_clock;
  logic [4:0]  txaddr, rxaddr;
  logic [7:0]  txdata, rxdata;
  logic [9:0]  txq [$];
  logic [2:0]  lamp_q;
  logic [7:0]  bases [3] = '{8'h40, 8'h80, 8'hC0};
  int          low_n [3], seen [3], want [3] = '{223, 223, 5};
  int          err_count = 0, n_compared = 0, k = 0, nm = 0;

  apc_top i_apc_top (.CLK_SYS_I(clk), .ARST_N_I(arst_n),
    .REG_ADDR_I(reg_addr), .REG_WDATA_I(reg_wdata), .REG_WR_I(reg_wr),
    .REG_RD_I(reg_rd), .REG_RDATA_O(reg_rdata), .RXCLK_I(rxclk),
    .RXADDR_I(rxaddr), .RXEN_N_I(rxen_n), .RXDATA_O(rxdata),
    .RXPARITY_O(rxpar), .RXSOC_O(rxsoc), .RXCLAV_O(rxclav),
    .RXCLAV_OE_N_O(rxclav_oe_n), .TXCLK_I(txclk), .TXADDR_I(txaddr),
    .TXEN_N_I(txen_n), .TXDATA_I(txdata), .TXPARITY_I(txpar),
    .TXSOC_I(txsoc), .TXCLAV_O(txclav), .TXCLAV_OE_N_O(txclav_oe_n),
    .IRQ_LINE_N_O(irq_n), .IRQ_LINE_OE_N_O(irq_oe_n),
    .LINE_RATE_CLOCK_SOURCE_I(osc), .RECEIVE_ACTIVITY_LAMP_O(lamp[0]),
    .TRANSMIT_ACTIVITY_LAMP_O(lamp[1]),
    .RECEIVED_TIMING_MARKER_PULSE_O(lamp[2]),
    .TRANSMIT_TIMING_MARKER_TRIGGER_I(trig), .RX_BIT_CLK_I(rbc),
    .RECOVERED_BIT_CLOCK_O(recovered_bit_clock), .UNUSED_OUTPUT_FLOAT_O(),
    .LINE_RX_I(line_rx), .LINE_RX_VALID_I(rx_vld), .LINE_RX_ERR_I(rx_err),
    .LINE_RX_MARKER_I(rx_mark), .LINE_GOOD_SIGNAL_I(good),
    .LINE_TX_SLOT_I(slot), .LINE_TX_O(line_tx), .LINE_TX_VALID_O(tx_vld),
    .LINE_TX_MARKER_O(tx_mark));
  apc_layer_model i_apc_layer_model (.txclk_o(txclk), .rxclk_o(rxclk),
    .txaddr_o(txaddr), .txen_n_o(txen_n), .txdata_o(txdata),
    .txpar_o(txpar), .txsoc_o(txsoc), .rxaddr_o(rxaddr), .rxen_n_o(rxen_n),
    .rxdata_i(rxdata), .rxpar_i(rxpar), .rxsoc_i(rxsoc));

  always #25 clk = ~clk;
  // oscillator slowed so the 20 MHz sampler sees every edge
  always #175 osc = ~osc;
  always @(posedge osc) begin
    for (int i = 0; i < 3; i++) if (lamp[i] === 1'b0) low_n[i]++;
  end
  // slots two cycles apart because the cell memory read is registered
  always @(posedge clk) begin
    rbc <= ~rbc;
    slot <= slot_run & ~slot;
    if (tx_vld === 1'b1) txq.push_back({tx_mark, line_tx});
    lamp_q <= lamp;
    for (int i = 0; i < 3; i++) begin
      if (arst_n && lamp[i] === 1'b1 && lamp_q[i] === 1'b0) begin
        // one osc edge of slack for the sampling pipeline
        chk(16'((low_n[i] >= want[i] - 1 && low_n[i] <= want[i] + 1)
            ? want[i] : low_n[i]), 16'(want[i]));
        seen[i]++;
        low_n[i] = 0;
      end
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rd_reg
  task automatic wait_seen(input int i, input int n);
    for (int t = 0; t < 6000 && seen[i] < n; t++) @(posedge clk);
    chk(16'(seen[i]), 16'(n));
  endtask : wait_seen
  task automatic line_cell(input logic [7:0] base, input logic err);
    for (int i = 0; i < 53; i++) begin
      @(posedge clk);
      line_rx <= '{soc: (i == 0), data: base + 8'(i)};
      rx_vld <= 1'b1;
      rx_err <= err;
      @(posedge clk);
      rx_vld <= 1'b0;
    end
  endtask : line_cell
  task automatic check_rx(input logic [7:0] base);
    logic [7:0] d;
    for (int i = 0; i < 53; i++) begin
      d = base + 8'(i);
      chk(16'(i_apc_layer_model.rxq[i]), 16'({i == 0, ~^d, d}));
    end
  endtask : check_rx
  task automatic print_verdict();
    if (err_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  initial begin
    #1_500_000;
    err_count++;
    print_verdict();
  end
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    rd_reg(OFS_CTRL, 16'h0020);
    rd_reg(OFS_MARK_WIDTH, 16'h0008);
    rd_reg(OFS_IRQ_STAT, 16'h0000);
    rd_reg(8'h1F, 16'h0000);
    wr_reg(OFS_CTRL, 16'h0023);
    wr_reg(OFS_MARK_WIDTH, 16'h0005);
    wr_reg(OFS_IRQ_MASK, 16'h0002);
    rd_reg(OFS_IRQ_MASK, 16'h0002);
    i_apc_layer_model.poll(5'h04);
    chk(16'({txclav_oe_n, rxclav_oe_n}), 16'h0003);
    i_apc_layer_model.poll(5'h03);
    chk(16'({txclav_oe_n, txclav, rxclav_oe_n, rxclav}), 16'h0004);
    // odd delay of a toggling clock: output is its inverse
    repeat (2) begin
      @(posedge clk);
      chk(16'(recovered_bit_clock ^ rbc), 16'h0001);
    end
    // slow first cell with a parity fault in byte 7, then two prompt ones
    i_apc_layer_model.send_cell(bases[0], 7, 2);
    wait_seen(1, 1);
    rd_reg(OFS_IRQ_STAT, 16'h0001);
    chk(16'(irq_oe_n), 16'h0001);
    i_apc_layer_model.send_cell(bases[1], 99, 0);
    wait_seen(1, 2);
    i_apc_layer_model.send_cell(bases[2], 99, 0);
    repeat (10) @(posedge clk);
    rd_reg(OFS_STATUS, 16'h0019);
    chk(16'({txclav_oe_n, txclav}), 16'h0000);
    slot_run <= 1'b1;
    repeat (40) @(posedge clk);
    trig <= 1'b0;
    repeat (10) @(posedge clk);
    trig <= 1'b1;
    for (int t = 0; t < 600 && txq.size() < 160; t++) @(posedge clk);
    chk(16'(txq.size()), 16'd160);
    foreach (txq[j]) begin
      if (txq[j][9]) begin
        chk(16'(txq[j]), 16'h0200);
        chk(16'(j > 0 && j < 53), 16'h0001);
        nm++;
      end else begin
        chk(16'(txq[j]), 16'({k % 53 == 0, bases[k / 53] + 8'(k % 53)}));
        k++;
      end
    end
    chk(16'(nm), 16'h0001);
    chk(16'(txclav), 16'h0001);
    wait_seen(1, 3);
    line_cell(8'h30, 1'b0);
    line_cell(8'h60, 1'b1);
    rx_err <= 1'b0;
    repeat (10) @(posedge clk);
    rd_reg(OFS_STATUS, 16'h0005);
    chk(16'({rxclav_oe_n, rxclav}), 16'h0001);
    i_apc_layer_model.recv_cell();
    check_rx(8'h30);
    wait_seen(0, 1);
    i_apc_layer_model.recv_cell();
    check_rx(8'h60);
    chk(16'({lamp[0], rxclav}), 16'h0002);
    @(posedge clk);
    rx_mark <= 1'b1;
    @(posedge clk);
    rx_mark <= 1'b0;
    repeat (20) @(posedge clk);
    chk(16'({irq_n, irq_oe_n}), 16'h0000);
    wait_seen(2, 1);
    chk(16'(irq_oe_n), 16'h0000);
    rd_reg(OFS_IRQ_STAT, 16'h0002);
    repeat (2) @(posedge clk);
    chk(16'(irq_oe_n), 16'h0001);
    good <= 1'b0;
    repeat (10) @(posedge clk);
    rd_reg(OFS_STATUS, 16'h0000);
    rd_reg(OFS_IRQ_STAT, 16'h0004);
    // parity check off: a bad byte must leave the status clear
    wr_reg(OFS_CTRL, 16'h0003);
    i_apc_layer_model.send_cell(bases[0], 0, 0);
    repeat (10) @(posedge clk);
    rd_reg(OFS_IRQ_STAT, 16'h0000);
    print_verdict();
  end
endmodule : apc_top_tb
